// [design/vic_arb.sv]
// Priority arbiter choosing the winning pending source.
`timescale 1ns/1ps
`default_nettype none
module vic_arb
  import vic_pkg::*;
(
  input  wire logic [NUM_SRC-1:0]         pend,
  input  wire logic [PRIO_WORDS-1:0][31:0] prio,
  output logic                            win_valid,
  output logic [4:0]                      win_idx,
  output logic [2:0]                      win_level,
  output logic [1:0]                      win_sub
);

  // Strict comparison keeps the lowest numbered source on a full tie.
  always_comb begin
    win_valid = 1'b0;
    win_idx   = 5'h00;
    win_level = 3'h0;
    win_sub   = 2'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (pend[i] && (prio_level(prio, 5'(i)) > win_level ||
          (prio_level(prio, 5'(i)) == win_level && prio_sub(prio, 5'(i)) > win_sub && win_valid))) begin
        win_valid = 1'b1;
        win_idx   = 5'(i);
        win_level = prio_level(prio, 5'(i));
        win_sub   = prio_sub(prio, 5'(i));
      end
    end
  end

endmodule
`default_nettype wire

// [design/vic_top.sv]
// Vectored interrupt controller: registers, pin edges, proximity timer and core request.
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module vic_top
  import vic_pkg::*;
(
  input  wire logic              SYS_CLK,
  input  wire logic              RST_B,
  input  wire logic [11:0]       ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic [31:0]            RDATA,
  input  wire logic [NUM_SRC-1:0] SRC_IRQ,
  input  wire logic [NUM_EXT-1:0] EXT_PIN,
  input  wire logic              IRQ_ACK,
  output logic                   IRQ_REQ,
  output logic [7:0]             IRQ_NUM,
  output logic [2:0]             IRQ_LEVEL,
  output logic [1:0]             IRQ_SUB,
  output logic                   IRQ_SHADOW,
  output logic                   IRQ_MULTI,
  output logic [15:0]            IRQ_VEC_OFFSET,
  output logic                   TMR_RUNNING
);

  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed {
    logic [31:0]                  ctrl;
    logic [31:0]                  shadow;
    logic [31:0]                  reload;
    logic [NUM_SRC-1:0]           flags;
    logic [NUM_SRC-1:0]           enables;
    logic [PRIO_WORDS-1:0][31:0]  prio;
    logic [2:0]                   req_level_st;
    logic [7:0]                   last_srv;
    logic [NUM_EXT-1:0]           pin_prev;
    logic                         tmr_run;
    logic [31:0]                  tmr_cnt;
    logic                         req;
    logic [7:0]                   num;
    logic [2:0]                   lvl;
    logic [1:0]                   sub;
    logic                         shadow_out;
    logic                         multi;
    logic [15:0]                  voff;
    logic [31:0]                  rdata;
  } vic_state_s;

  localparam vic_state_s STATE_RESET = '0;

  vic_state_s         st;
  vic_state_s         next_st;
  logic               multi;
  logic [2:0]         tpc;
  logic [NUM_SRC-1:0] set_evt;
  logic [NUM_SRC-1:0] qual;
  logic [NUM_SRC-1:0] held;
  logic [NUM_SRC-1:0] pend;
  logic               win_valid;
  logic [4:0]         win_idx;
  logic [2:0]         win_level;
  logic [1:0]         win_sub;
  logic [7:0]         pidx;
  logic               prio_hit;
  logic [1:0]         op;
  logic [7:0]         slot;
  logic               tmr_start;

  assign multi = st.ctrl[CTRL_MULTI_BIT];
  assign tpc   = st.ctrl[CTRL_TPC_LSB +: 3];
  assign slot  = ADDR[11:4];
  assign op    = ADDR[3:2];
  assign pidx  = slot - OFF_PRIO0[11:4];
  assign prio_hit = pidx < 8'(PRIO_WORDS);

  // ******************************************************************
  // Request events, timer qualification and pending set
  // ******************************************************************
  // Pins are sampled on the system clock; a pin high out of reset gives no
  // edge, as pin_prev resets to 0 and the polarity bits reset to falling.
  always_comb begin
    set_evt = SRC_IRQ;
    for (int k = 0; k < NUM_EXT; k++) begin
      if (st.ctrl[k]) begin
        set_evt[k] = SRC_IRQ[k] | (EXT_PIN[k] & ~st.pin_prev[k]);
      end else begin
        set_evt[k] = SRC_IRQ[k] | (~EXT_PIN[k] & st.pin_prev[k]);
      end
    end
    for (int i = 0; i < NUM_SRC; i++) begin
      qual[i] = (tpc != 3'h0) && (prio_level(st.prio, 5'(i)) != 3'h0) &&
                (prio_level(st.prio, 5'(i)) <= tpc);
      held[i] = st.tmr_run && qual[i];
    end
    pend      = st.flags & st.enables & ~held;
    tmr_start = !st.tmr_run && |(set_evt & st.enables & qual);
  end

  vic_arb u_arb (
    .pend      (pend),
    .prio      (st.prio),
    .win_valid (win_valid),
    .win_idx   (win_idx),
    .win_level (win_level),
    .win_sub   (win_sub)
  );

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    next_st          = st;
    next_st.pin_prev = EXT_PIN;

    if (WR) begin
      case (1'b1)
        slot == OFF_CTRL[11:4]:
          next_st.ctrl = alias_apply(st.ctrl, WDATA, op, MASK_CTRL);
        slot == OFF_SHADOW[11:4]:
          next_st.shadow = alias_apply(st.shadow, WDATA, op, MASK_SHADOW);
        slot == OFF_RELOAD[11:4]:
          next_st.reload = alias_apply(st.reload, WDATA, op, MASK_FULL);
        slot == OFF_FLAGS[11:4]:
          next_st.flags = alias_apply(st.flags, WDATA, op, MASK_FULL);
        slot == OFF_ENABLE[11:4]:
          next_st.enables = alias_apply(st.enables, WDATA, op, MASK_FULL);
        prio_hit:
          next_st.prio[pidx[2:0]] = alias_apply(st.prio[pidx[2:0]], WDATA, op, MASK_PRIO);
        default: begin
        end
      endcase
    end
    // A request arriving with a software clear still leaves its flag set.
    next_st.flags = next_st.flags | set_evt;

    // The timer counts system clocks; a reload of zero expires on the next edge.
    if (tmr_start) begin
      next_st.tmr_run = 1'b1;
      next_st.tmr_cnt = st.reload;
    end else if (st.tmr_run) begin
      if (st.tmr_cnt == 32'h00000000) begin
        next_st.tmr_run = 1'b0;
      end else begin
        next_st.tmr_cnt = st.tmr_cnt - 32'h00000001;
      end
    end

    next_st.req   = win_valid;
    next_st.num   = {3'b000, win_idx};
    next_st.lvl   = win_level;
    next_st.sub   = win_sub;
    next_st.multi = multi;
    if (multi) begin
      next_st.shadow_out = st.shadow[{win_level, 2'b00} +: 4] == SHADOW_SET1;
      next_st.voff       = vec_offset({3'b000, win_idx}, st.ctrl[CTRL_VS_LSB +: 7]);
    end else begin
      next_st.shadow_out = st.shadow[0];
      next_st.voff       = 16'h0000;
    end
    if (win_valid) begin
      next_st.req_level_st = win_level;
    end
    if (IRQ_ACK && st.req) begin
      next_st.last_srv = st.num;
    end

    next_st.rdata = RESET_WORD;
    if (RD) begin
      case (1'b1)
        slot == OFF_CTRL[11:4]:   next_st.rdata = st.ctrl;
        slot == OFF_SHADOW[11:4]: next_st.rdata = st.shadow;
        slot == OFF_STATUS[11:4]: next_st.rdata = {21'h0, st.req_level_st, st.last_srv};
        slot == OFF_RELOAD[11:4]: next_st.rdata = st.reload;
        slot == OFF_FLAGS[11:4]:  next_st.rdata = st.flags;
        slot == OFF_ENABLE[11:4]: next_st.rdata = st.enables;
        prio_hit:                 next_st.rdata = st.prio[pidx[2:0]];
        default:                  next_st.rdata = RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA          = st.rdata;
  assign IRQ_REQ        = st.req;
  assign IRQ_NUM        = st.num;
  assign IRQ_LEVEL      = st.lvl;
  assign IRQ_SUB        = st.sub;
  assign IRQ_SHADOW     = st.shadow_out;
  assign IRQ_MULTI      = st.multi;
  assign IRQ_VEC_OFFSET = st.voff;
  assign TMR_RUNNING    = st.tmr_run;

  // ******************************************************************
  // Checks
  // ******************************************************************
  logic [NUM_SRC-1:0] past_pend;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      past_pend <= '0;
    end else begin
      past_pend <= pend;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  a_spacing_ignored: assert property (IRQ_REQ && !IRQ_MULTI |-> IRQ_VEC_OFFSET == 16'h0000)
    else $error("vector offset not zero in single mode");
  a_spacing_scale: assert property ($past(st.ctrl[CTRL_VS_LSB +: 7]) == 7'h02 && IRQ_REQ && IRQ_MULTI
    |-> IRQ_VEC_OFFSET == {4'h0, IRQ_NUM, 4'h0})
    else $error("vector spacing of 16 bytes not applied");
  a_mode_follow: assert property (IRQ_MULTI == $past(st.ctrl[CTRL_MULTI_BIT]))
    else $error("mode output does not follow control bit");
  a_timer_off: assert property (tpc == 3'h0 && !st.tmr_run |=> !st.tmr_run)
    else $error("timer started while disabled");
  a_timer_load: assert property ($rose(st.tmr_run) |-> st.tmr_cnt == $past(st.reload))
    else $error("timer not loaded from reload value");
  a_timer_hold: assert property ($past(st.tmr_run) && $past(tpc) != 3'h0 && IRQ_REQ
    |-> IRQ_LEVEL > $past(tpc))
    else $error("held level presented while timer runs");
  a_flag_set_wins: assert property ((|set_evt) |=> (st.flags & $past(set_evt)) == $past(set_evt))
    else $error("request event lost");
  a_req_pending: assert property (IRQ_REQ |-> past_pend[IRQ_NUM[4:0]] && IRQ_LEVEL != 3'h0)
    else $error("request presented for a source not pending");
  a_reserved_zero: assert property ($past(RD && slot == OFF_CTRL[11:4]) |-> (RDATA & ~MASK_CTRL) == 32'h0)
    else $error("reserved control bits read nonzero");
  a_shadow_single: assert property (IRQ_REQ && !IRQ_MULTI |-> IRQ_SHADOW == $past(st.shadow[0]))
    else $error("single vector shadow choice wrong");
  a_status_level: assert property (IRQ_REQ |-> st.req_level_st == IRQ_LEVEL)
    else $error("level status does not match presented level");
  a_serviced_num: assert property (IRQ_ACK && IRQ_REQ |=> st.last_srv == $past(IRQ_NUM))
    else $error("serviced number not recorded");
  a_alias_clear: assert property ($past(WR && ADDR == (OFF_FLAGS | 12'h004) && set_evt == '0)
    |-> (st.flags & $past(WDATA)) == '0)
    else $error("clear alias did not clear flags");

  c_timer_start: cover property ($rose(st.tmr_run));
  c_timer_expire: cover property ($fell(st.tmr_run) ##[1:4] IRQ_REQ);
  c_multi_req: cover property (IRQ_REQ && IRQ_MULTI && IRQ_SHADOW);
  c_ack: cover property (IRQ_ACK && IRQ_REQ);

endmodule
`default_nettype wire

// [shared/vic_pkg.sv]
// Register map, field layout and shared helpers of the vectored interrupt controller.
// Behaviour
// - One-hot spacing code gives 8 to 512 bytes.
// - Spacing ignored while single-vector mode selected.
// - Control bit 12 selects multi-vector mode.
// - Trigger level 0 disables; n starts at <=n.
// - Five pin polarity bits: 1 rising, 0 falling.
// - Per-level shadow field: 0000 set0, 0001 set1.
// - Per-level shadow fields ignored in single mode.
// - Single mode: bit 0 enables shadow set.
// - Status holds level of latest presented request.
// - Status holds number of last serviced request.
// - Timer loads reload value on a trigger while idle.
// - Flag reads 1 after request; writable; resets 0.
// - Enable bit 1 permits, 0 blocks; resets 0.
// - Unimplemented bits read zero, ignore writes.
// - Priority 0 disables source; subpriority 0 to 3.
// - Clear, set, invert aliases at +4, +8, +C.
package vic_pkg;

  localparam int          NUM_SRC        = 32;
  localparam int          NUM_EXT        = 5;
  localparam int          PRIO_WORDS     = 8;
  localparam logic [11:0] OFF_CTRL       = 12'h000;
  localparam logic [11:0] OFF_SHADOW     = 12'h010;
  localparam logic [11:0] OFF_STATUS     = 12'h020;
  localparam logic [11:0] OFF_RELOAD     = 12'h030;
  localparam logic [11:0] OFF_FLAGS      = 12'h040;
  localparam logic [11:0] OFF_ENABLE     = 12'h080;
  localparam logic [11:0] OFF_PRIO0      = 12'h0C0;
  localparam logic [1:0]  OP_WRITE       = 2'h0;
  localparam logic [1:0]  OP_CLEAR       = 2'h1;
  localparam logic [1:0]  OP_SET         = 2'h2;
  localparam logic [1:0]  OP_INVERT      = 2'h3;
  localparam int          CTRL_VS_LSB    = 16;
  localparam int          CTRL_MULTI_BIT = 12;
  localparam int          CTRL_TPC_LSB   = 8;
  localparam logic [31:0] MASK_CTRL      = 32'h007F171F;
  localparam logic [31:0] MASK_SHADOW    = 32'hFFFFFFF1;
  localparam logic [31:0] MASK_PRIO      = 32'h1F1F1F1F;
  localparam logic [31:0] MASK_FULL      = 32'hFFFFFFFF;
  localparam logic [31:0] RESET_WORD     = 32'h00000000;
  localparam logic [3:0]  SHADOW_SET1    = 4'h1;

  // Priority of one source, taken from its word in the priority control array.
  function automatic logic [2:0] prio_level(input logic [PRIO_WORDS-1:0][31:0] words, input logic [4:0] idx);
    prio_level = words[idx[4:2]][{idx[1:0], 3'b010} +: 3];
  endfunction

  function automatic logic [1:0] prio_sub(input logic [PRIO_WORDS-1:0][31:0] words, input logic [4:0] idx);
    prio_sub = words[idx[4:2]][{idx[1:0], 3'b000} +: 2];
  endfunction

  // Plain, clear, set and invert writes share one path; reserved bits stay zero.
  function automatic logic [31:0] alias_apply(input logic [31:0] old, input logic [31:0] wdata,
                                              input logic [1:0] op, input logic [31:0] mask);
    logic [31:0] val;
    case (op)
      OP_CLEAR:  val = old & ~wdata;
      OP_SET:    val = old | wdata;
      OP_INVERT: val = old ^ wdata;
      default:   val = wdata;
    endcase
    alias_apply = val & mask;
  endfunction

  // Vector offset from request number; the highest set spacing bit decides, and a zero code gives 0.
  function automatic logic [15:0] vec_offset(input logic [7:0] num, input logic [6:0] spacing);
    logic [15:0] off;
    off = 16'h0000;
    for (int k = 0; k < 7; k++) begin
      if (spacing[k]) begin
        off = {8'h00, num} << (3 + k);
      end
    end
    vec_offset = off;
  endfunction

endpackage

// [testbench/vic_core_model.sv]
// Processor core model that takes presented interrupt requests after a set delay.
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  input  wire logic       irq_req,
  input  wire logic       take_en,
  input  wire logic [3:0] ack_delay,
  output logic            irq_ack
);
  logic [3:0] wait_cnt;

  // The acknowledge is a single-cycle pulse, so a request that stays up is taken again after the delay.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_ack  <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (irq_ack) begin
      irq_ack  <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (irq_req && take_en) begin
      if (wait_cnt == ack_delay) begin
        irq_ack <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      wait_cnt <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// [testbench/vic_top_tb.sv]
// Self-checking testbench of the vectored interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module vic_top_tb
  import vic_pkg::*;
();
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} vic_row_s;
  logic              SYS_CLK = 1'b0;
  logic              RST_B   = 1'b0;
  logic [11:0]       addr    = 12'h000;
  logic [31:0]       wdata   = 32'h0;
  logic              wr      = 1'b0;
  logic              rd      = 1'b0;
  logic [31:0]       rdata;
  logic [31:0]       src     = 32'h0;
  logic [4:0]        pin     = 5'h00;
  logic              take_en = 1'b0;
  logic [3:0]        dly     = 4'h4;
  logic              ack, req, multi, shadow, running;
  logic [7:0]        num;
  logic [2:0]        lvl;
  logic [1:0]        sub;
  logic [15:0]       voff;
  int                error_cnt = 0;
  int                checks_done = 0;
  vic_row_s          rows [18];
  int                cnt, bad, w;
  logic [31:0]       sc [5][3];
  logic [11:0]       bases [7];

  always #50 SYS_CLK = ~SYS_CLK;

  vic_top DUT (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
               .RDATA(rdata), .SRC_IRQ(src), .EXT_PIN(pin), .IRQ_ACK(ack), .IRQ_REQ(req),
               .IRQ_NUM(num), .IRQ_LEVEL(lvl), .IRQ_SUB(sub), .IRQ_SHADOW(shadow),
               .IRQ_MULTI(multi), .IRQ_VEC_OFFSET(voff), .TMR_RUNNING(running));
  vic_core_model core (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .irq_req(req), .take_en(take_en),
                       .ack_delay(dly), .irq_ack(ack));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge SYS_CLK);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken at its falling edge.
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    @(posedge SYS_CLK);
    addr <= a;
    rd   <= 1'b1;
    @(posedge SYS_CLK);
    rd   <= 1'b0;
    @(negedge SYS_CLK);
    check(nm, exp, rdata);
  endtask

  task automatic pulse(input logic [31:0] m);
    @(posedge SYS_CLK);
    src <= m;
    @(posedge SYS_CLK);
    src <= 32'h0;
  endtask

  task automatic settle();
    repeat (3) @(negedge SYS_CLK);
  endtask

  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rows = '{'{OFF_CTRL, 32'hFFC0FFFF, 32'h0040171F}, '{12'h004, 32'h00001000, 32'h0040071F},
             '{12'h008, 32'h00001000, 32'h0040171F}, '{12'h00C, 32'h0000001F, 32'h00401700},
             '{OFF_CTRL, 32'h0, 32'h0}, '{OFF_SHADOW, 32'hFFFFFFFF, MASK_SHADOW},
             '{12'h014, 32'hFFFFFFFF, 32'h0}, '{OFF_STATUS, 32'hFFFFFFFF, 32'h0},
             '{OFF_RELOAD, 32'h12345678, 32'h12345678}, '{12'h034, 32'hFFFFFFFF, 32'h0},
             '{12'h048, 32'hA5A5A5A5, 32'hA5A5A5A5}, '{12'h04C, 32'hFFFFFFFF, 32'h5A5A5A5A},
             '{OFF_FLAGS, 32'h0, 32'h0}, '{OFF_ENABLE, 32'hFFFFFFFF, 32'hFFFFFFFF},
             '{OFF_ENABLE, 32'h0, 32'h0}, '{12'h130, 32'hFFFFFFFF, MASK_PRIO},
             '{12'h130, 32'h0, 32'h0}, '{12'h300, 32'hFFFFFFFF, 32'h0}};
    bases = '{OFF_CTRL, OFF_SHADOW, OFF_STATUS, OFF_RELOAD, OFF_FLAGS, OFF_ENABLE, OFF_PRIO0};
    repeat (2) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    foreach (bases[i]) rchk("reset_value", bases[i], RESET_WORD);
    foreach (rows[i]) begin
      wr32(rows[i].a, rows[i].d);
      rchk("reg_readback", rows[i].a & 12'hFF0, rows[i].e);
    end
    wr32(OFF_ENABLE, 32'h00000228);
    wr32(12'h0C0, 32'h15000000);
    wr32(12'h0D0, 32'h1F000000);
    wr32(12'h0E0, 32'h00001600);
    pulse(32'h000002A8);
    settle();
    check("winner", {1'b1, 8'd9, 3'd5, 2'd2}, {req, num, lvl, sub});
    rchk("flags_set", OFF_FLAGS, 32'h000002A8);
    wr32(12'h044, 32'h00000200);
    settle();
    check("second", {1'b1, 8'd3, 3'd5, 2'd1}, {req, num, lvl, sub});
    wr32(12'h044, 32'h00000008);
    settle();
    check("blocked", 32'h0, {31'h0, req});
    pulse(32'h00000008);
    for (int k = 0; k < 7; k++) begin
      wr32(OFF_CTRL, 32'h00001000 | (32'h00010000 << k));
      settle();
      check("vec_offset", 32'h3 << (3 + k), {16'h0, voff});
    end
    wr32(OFF_CTRL, 32'h00001000);
    settle();
    check("zero_space", {1'b1, 16'h0}, {multi, voff});
    wr32(OFF_CTRL, 32'h00400000);
    settle();
    check("single_space", {1'b0, 16'h0}, {multi, voff});
    sc = '{'{32'h1000, 32'h00100000, 32'h1}, '{32'h1000, 32'h00200000, 32'h0},
           '{32'h1000, 32'h00000001, 32'h0}, '{32'h0, 32'h00100000, 32'h0},
           '{32'h0, 32'h00000001, 32'h1}};
    foreach (sc[i]) begin
      wr32(OFF_CTRL, sc[i][0]);
      wr32(OFF_SHADOW, sc[i][1]);
      settle();
      check("shadow", sc[i][2], {31'h0, shadow});
    end
    take_en <= 1'b1;
    for (w = 0; w < 20 && ack !== 1'b1; w++) @(posedge SYS_CLK);
    if (w == 20) begin
      error_cnt++;
      end_sim();
    end
    take_en <= 1'b0;
    settle();
    rchk("status", OFF_STATUS, 32'h00000503);
    wr32(OFF_FLAGS, 32'h0);
    wr32(OFF_CTRL, 32'h00000004);
    @(posedge SYS_CLK);
    pin <= 5'h14;
    settle();
    rchk("pin_rise", OFF_FLAGS, 32'h00000004);
    @(posedge SYS_CLK);
    pin <= 5'h00;
    settle();
    rchk("pin_fall", OFF_FLAGS, 32'h00000014);
    wr32(OFF_FLAGS, 32'h0);
    wr32(OFF_RELOAD, 32'd10);
    wr32(12'h088, 32'h00000002);
    wr32(12'h0C8, 32'h00000800);
    foreach (sc[i]) begin
      if (i < 4) begin
        wr32(OFF_CTRL, {21'h0, 3'(i), 8'h00});
        pulse(32'h00000002);
        cnt = 0;
        bad = 0;
        for (int c = 0; c < 40; c++) begin
          @(negedge SYS_CLK);
          if (running === 1'b1) cnt++;
          if (running === 1'b1 && req !== 1'b0) bad++;
        end
        check("timer_cycles", (i >= 2) ? 32'd11 : 32'd0, cnt);
        check("held_out", {1'b1, 31'h0}, {req, 31'(bad)});
        wr32(12'h044, 32'h00000002);
      end
    end
    wr32(OFF_CTRL, 32'h0040171F);
    @(posedge SYS_CLK);
    RST_B <= 1'b0;
    @(posedge SYS_CLK);
    RST_B <= 1'b1;
    rchk("rerun_ctrl", OFF_CTRL, RESET_WORD);
    rchk("rerun_enable", OFF_ENABLE, RESET_WORD);
    end_sim();
  end
endmodule
`default_nettype wire
